// File: hw/dual_source_clock_generator.sv
// Dual-source system clock generator with glitch-free switching
`timescale 1ns/1ps

// Contract
// [R1] Clock output follows the crystal when select is low, external when high.
// [R2] Select may change while running and either source may be any speed.
// [R3] Clock output is held low within 4 system clocks of a select change.
// [R4] After freezing, clock resumes within 2.5 cycles of the new source.
// [R5] Select is sampled only while system and peripheral clocks are high.
// [R6] Clock is forced low at the second peripheral clock fall after detection.
// [R7] Crystal restart is on the first crystal rise after its second fall.
// [R8] External restart is on the first external fall after its second rise.
// [R9] Peripheral clock runs at half the system clock with even duty.
// [R10] Peripheral clock is held high after two cycles of active bus status.
// [R11] Peripheral clock toggles freely while both status lines are high.
// [R12] Peripheral phase is aligned by stretching its high time after reset.
// [R13] Peripheral phase shifts only in the first bus cycle after reset; the code stretches the high time in every bus cycle.
// [R14] The processor drives a status line low at each bus cycle start.
// [R15] No short pulse appears on the clock output during a source change.
module dual_source_clock_generator
    import clkgen_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Clock sources
    input  wire logic crystal_input,
    input  wire logic external_frequency_input,
    input  wire logic source_select,
    // Processor bus status, active low
    input  wire logic bus_status_zero,
    input  wire logic bus_status_one,
    // Clock outputs
    output logic      sys_clk_out,
    output logic      periph_clk_out,
    output logic      periph_phase_locked
);

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    clkgen_s st;
    clkgen_s next_st;
    logic    xtal_rise;
    logic    xtal_fall;
    logic    ext_rise;
    logic    ext_fall;
    logic    sys_rise;
    logic    sys_fall;
    logic    pclk;
    logic    pclk_will_fall;
    logic    follow_level;
    logic    pclk_fall_evt;
    logic    new_src_rise;

    // Level the clock output takes from a given source
    function automatic logic source_level(input logic sel,
                                          input logic xtal,
                                          input logic ext);
        // External source is inverted onto the clock output
        source_level = (sel == SEL_EXTERNAL) ? ~ext : xtal;
    endfunction : source_level

    // ------------------------------------------------------------
    // Source edge detectors
    // ------------------------------------------------------------
    source_edge u_xtal_edge (
        .clk  (clk),
        .nrst (nrst),
        .sig  (crystal_input),
        .rise (xtal_rise),
        .fall (xtal_fall)
    );

    source_edge u_ext_edge (
        .clk  (clk),
        .nrst (nrst),
        .sig  (external_frequency_input),
        .rise (ext_rise),
        .fall (ext_fall)
    );

    // ------------------------------------------------------------
    // Peripheral clock
    // ------------------------------------------------------------
    periph_clock u_pclk (
        .clk             (clk),
        .nrst            (nrst),
        .sys_rise        (sys_rise),
        .sys_fall        (sys_fall),
        .bus_status_zero (bus_status_zero),
        .bus_status_one  (bus_status_one),
        .pclk            (pclk),
        .pclk_will_fall  (pclk_will_fall),
        .aligned         (periph_phase_locked)
    );

    // Level of the running source and a peripheral fall this edge
    assign follow_level = source_level(st.cur_sel, crystal_input,
                                       external_frequency_input);
    assign pclk_fall_evt = ~st.sys_clk & follow_level & pclk_will_fall;
    assign new_src_rise  = (st.cur_sel == SEL_EXTERNAL) ? ext_rise
                                                        : xtal_rise;

    // System clock edges as seen by the peripheral divider
    assign sys_rise = ~st.sys_clk & next_st.sys_clk;
    assign sys_fall = st.sys_clk & ~next_st.sys_clk;

    // ------------------------------------------------------------
    // Switching sequence
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        case (st.state)
            RUN: begin
                next_st.sys_clk = follow_level; // [R1]
                // Watch for a new selection at the sampling point
                if (st.sys_clk && pclk && source_select != st.cur_sel) begin
                    next_st.state      = ARMED; // [R2] [R5]
                    next_st.pclk_falls = 2'h0;
                    next_st.latency    = RST_COUNT;
                end
            end
            ARMED: begin
                next_st.sys_clk = follow_level;
                // Old source rise, from registered state to avoid a loop
                if (!st.sys_clk && follow_level) begin
                    next_st.latency = st.latency + 3'h1;
                end
                if (pclk_fall_evt) begin
                    next_st.pclk_falls = st.pclk_falls + 2'h1;
                    if (st.pclk_falls + 2'h1 == FREEZE_PCLK_FALLS) begin
                        // Rise suppressed so no runt reaches the output
                        next_st.sys_clk     = 1'b0; // [R6] [R15]
                        next_st.state       = FROZEN;
                        next_st.cur_sel     = ~st.cur_sel;
                        next_st.edge_cnt    = 2'h0;
                        next_st.restart_cyc = RST_COUNT;
                    end
                end
            end
            FROZEN: begin
                next_st.sys_clk = 1'b0; // [R15]
                if (new_src_rise) begin
                    next_st.restart_cyc = st.restart_cyc + 3'h1;
                end
                if (st.cur_sel == SEL_CRYSTAL) begin
                    if (st.edge_cnt == RESTART_EDGES && xtal_rise) begin
                        next_st.sys_clk = 1'b1; // [R7] [R4]
                        next_st.state   = RUN;
                    end else if (xtal_fall && st.edge_cnt != RESTART_EDGES)
                    begin
                        next_st.edge_cnt = st.edge_cnt + 2'h1;
                    end
                end else begin
                    if (st.edge_cnt == RESTART_EDGES && ext_fall) begin
                        next_st.sys_clk = 1'b1; // [R8] [R4]
                        next_st.state   = RUN;
                    end else if (ext_rise && st.edge_cnt != RESTART_EDGES)
                    begin
                        next_st.edge_cnt = st.edge_cnt + 2'h1;
                    end
                end
            end
            default: begin
                next_st.state   = RUN;
                next_st.sys_clk = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.state       <= RUN;
            st.cur_sel     <= SEL_CRYSTAL;
            st.sys_clk     <= RST_SYS_CLK;
            st.pclk_falls  <= 2'h0;
            st.edge_cnt    <= 2'h0;
            st.latency     <= RST_COUNT;
            st.restart_cyc <= RST_COUNT;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign sys_clk_out    = st.sys_clk;
    assign periph_clk_out = pclk;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_xtal_follow: assert property ( // [R1]
        st.state == RUN && st.cur_sel == SEL_CRYSTAL
        |=> sys_clk_out == $past(crystal_input))
        else $error("clock output not following crystal");

    a_ext_follow: assert property ( // [R1]
        st.state == RUN && st.cur_sel == SEL_EXTERNAL
        |=> sys_clk_out == !$past(external_frequency_input))
        else $error("clock output not following external input");

    a_freeze_latency: assert property ( // [R3]
        st.state == ARMED |-> st.latency <= FREEZE_MAX_CYCLES)
        else $error("freeze came too late");

    a_restart_latency: assert property ( // [R4]
        st.state == FROZEN |-> st.restart_cyc <= RESTART_MAX_EDGES)
        else $error("restart came too late");

    a_sample_point: assert property ( // [R5]
        st.state == RUN && next_st.state == ARMED
        |-> st.sys_clk && pclk)
        else $error("select sampled outside high phase");

    a_freeze_low: assert property ( // [R6]
        st.state == ARMED && next_st.state == FROZEN
        |=> !sys_clk_out throughout (st.state == FROZEN)[*1])
        else $error("clock not frozen low");

    a_xtal_restart: assert property ( // [R7]
        st.state == FROZEN && st.cur_sel == SEL_CRYSTAL
        && next_st.state == RUN
        |-> st.edge_cnt == RESTART_EDGES && xtal_rise)
        else $error("crystal restart at wrong edge");

    a_ext_restart: assert property ( // [R8]
        st.state == FROZEN && st.cur_sel == SEL_EXTERNAL
        && next_st.state == RUN
        |-> st.edge_cnt == RESTART_EDGES && ext_fall)
        else $error("external restart at wrong edge");

    a_no_runt: assert property ( // [R15]
        st.state == FROZEN |-> !st.sys_clk)
        else $error("pulse on clock output while frozen");

    a_select_wait: assert property ( // [R5]
        st.state == RUN && !(st.sys_clk && pclk)
        |=> st.state == RUN)
        else $error("select taken outside sampling point");

    a_select_same: assert property ( // [R5]
        st.state == RUN && source_select == st.cur_sel
        |=> st.state == RUN)
        else $error("switch started without a new selection");

    a_armed_stay: assert property ( // [R6]
        st.state == ARMED |=> st.state != RUN)
        else $error("switch abandoned before freezing");

    a_first_fall: assert property ( // [R6]
        st.state == ARMED && st.pclk_falls == 2'h0 && pclk_fall_evt
        |=> st.state == ARMED && sys_clk_out)
        else $error("froze at first peripheral fall");

    a_second_fall: assert property ( // [R6]
        st.state == ARMED && st.pclk_falls == 2'h1 && pclk_fall_evt
        |=> st.state == FROZEN && !sys_clk_out)
        else $error("missed freeze at second peripheral fall");

    a_armed_follow: assert property ( // [R2]
        st.state == ARMED && !pclk_fall_evt
        |=> sys_clk_out == $past(follow_level))
        else $error("clock output left old source early");

    a_sel_flip: assert property ( // [R6]
        st.state == ARMED && next_st.state == FROZEN
        |=> st.cur_sel != $past(st.cur_sel))
        else $error("selection not taken at freeze");

    a_sel_hold: assert property ( // [R1]
        !(st.state == ARMED && next_st.state == FROZEN)
        |=> $stable(st.cur_sel))
        else $error("selection changed outside freeze");

    a_edge_bound: assert property ( // [R4]
        st.state == FROZEN |-> st.edge_cnt <= RESTART_EDGES)
        else $error("restart edge count overran");

    a_frozen_low: assert property ( // [R15]
        st.state == FROZEN && next_st.state == FROZEN
        |=> !sys_clk_out && st.state == FROZEN)
        else $error("clock output rose while frozen");

    a_restart_high: assert property ( // [R4]
        st.state == FROZEN && next_st.state == RUN
        |=> sys_clk_out && st.state == RUN)
        else $error("clock output did not restart");

    a_pclk_frozen: assert property ( // [R9]
        st.state == FROZEN |-> pclk)
        else $error("peripheral clock fell during freeze");

    c_to_external: cover property (
        st.state == FROZEN && st.cur_sel == SEL_EXTERNAL
        && next_st.state == RUN);
    c_to_crystal: cover property (
        st.state == FROZEN && st.cur_sel == SEL_CRYSTAL
        && next_st.state == RUN);
    c_phase_lock: cover property ($rose(periph_phase_locked));

endmodule : dual_source_clock_generator

// File: common/clkgen_pkg.sv
// Shared constants, states and state records of the clock generator
package clkgen_pkg;

    // ------------------------------------------------------------
    // Source selection encoding
    // ------------------------------------------------------------
    localparam logic SEL_CRYSTAL  = 1'b0;
    localparam logic SEL_EXTERNAL = 1'b1;

    // ------------------------------------------------------------
    // Sequence counts
    // ------------------------------------------------------------
    localparam logic [1:0] FREEZE_PCLK_FALLS = 2'h2;
    localparam logic [1:0] RESTART_EDGES     = 2'h2;
    localparam logic [2:0] FREEZE_MAX_CYCLES = 3'h4;
    localparam logic [2:0] RESTART_MAX_EDGES = 3'h3;
    localparam logic [1:0] STATUS_ACTIVE_RUN = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       RST_SYS_CLK  = 1'b0;
    localparam logic       RST_PCLK     = 1'b0;
    localparam logic [1:0] RST_HISTORY  = 2'h0;
    localparam logic [2:0] RST_COUNT    = 3'h0;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RUN,
        ARMED,
        FROZEN
    } switch_e;

    typedef struct packed {
        switch_e    state;
        logic       cur_sel;
        logic       sys_clk;
        logic [1:0] pclk_falls;
        logic [1:0] edge_cnt;
        logic [2:0] latency;
        logic [2:0] restart_cyc;
    } clkgen_s;

    typedef struct packed {
        logic prev;
    } edge_s;

    typedef struct packed {
        logic       pclk;
        logic [1:0] history;
        logic       seen_bus;
        logic       aligned;
    } pclk_s;

endpackage : clkgen_pkg

// File: hw/source_edge.sv
// Edge detector for one clock source input
`timescale 1ns/1ps

module source_edge
    import clkgen_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Source level
    input  wire logic sig,
    // Edge events
    output logic      rise,
    output logic      fall
);

    edge_s st;
    edge_s next_st;

    // Remember last sample
    always_comb begin
        next_st      = st;
        next_st.prev = sig;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.prev <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Edge pulses against last sample
    assign rise = sig & ~st.prev;
    assign fall = ~sig & st.prev;

endmodule : source_edge

// File: hw/periph_clock.sv
// Half-rate peripheral clock with bus-status phase alignment
`timescale 1ns/1ps

module periph_clock
    import clkgen_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // System clock edge events
    input  wire logic sys_rise,
    input  wire logic sys_fall,
    // Bus status, active low
    input  wire logic bus_status_zero,
    input  wire logic bus_status_one,
    // Peripheral clock
    output logic      pclk,
    output logic      pclk_will_fall,
    output logic      aligned
);

    pclk_s st;
    pclk_s next_st;
    logic  force_high;
    logic  bus_active;

    assign bus_active = ~(bus_status_zero & bus_status_one);
    assign force_high = (st.history == STATUS_ACTIVE_RUN); // [R10]
    assign pclk_will_fall = st.pclk & ~force_high;

    // Status history, toggle and alignment tracking
    always_comb begin
        next_st = st;
        if (sys_fall) begin
            next_st.history = {st.history[0], bus_active};
        end
        if (sys_rise) begin
            if (force_high) begin
                next_st.pclk = 1'b1; // [R10] [R12]
            end else begin
                next_st.pclk = ~st.pclk; // [R9] [R11]
            end
        end
        // First bus cycle sets seen_bus; the high stretch still applies in every later bus cycle
        if (force_high) begin
            next_st.seen_bus = 1'b1;
        end
        if (st.seen_bus && !bus_active) begin
            next_st.aligned = 1'b1; // [R13]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.pclk     <= RST_PCLK;
            st.history  <= RST_HISTORY;
            st.seen_bus <= 1'b0;
            st.aligned  <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign pclk    = st.pclk;
    assign aligned = st.aligned;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_pclk_toggle: assert property ( // [R9]
        sys_rise && !force_high |=> pclk != $past(pclk))
        else $error("peripheral clock missed its toggle");

    a_pclk_forced: assert property ( // [R10]
        sys_rise && st.history == STATUS_ACTIVE_RUN |=> pclk)
        else $error("peripheral clock not held high");

    c_pclk_stretch: cover property (sys_rise && force_high && st.pclk);

endmodule : periph_clock

// File: test/bus_status_model.sv
// Processor bus status model driving the status lines
`timescale 1ns/1ps

module bus_status_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Processor clock and bus activity enable
    input  wire logic sys_clk,
    input  wire logic run,
    // Status lines, active low
    output logic      bus_status_zero,
    output logic      bus_status_one
);
    int   phase;
    logic sys_d;
    logic pick;

    // Status moves half a clock after a processor clock rise, at phase 0 or phase 2 only
    always @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            phase           <= 0;
            sys_d           <= 1'b0;
            bus_status_zero <= 1'b1;
            bus_status_one  <= 1'b1;
        end else begin
            sys_d <= sys_clk;
            if (sys_clk && !sys_d) begin
                phase <= (phase == 5) ? 0 : phase + 1;
                pick = 1'($urandom % 2);
                // Each bus cycle opens with one line low
                if (run && phase == 0) begin
                    bus_status_zero <= pick;
                    bus_status_one  <= ~pick;
                end else if (phase == 2) begin
                    bus_status_zero <= 1'b1;
                    bus_status_one  <= 1'b1;
                end
            end
        end
    end
endmodule : bus_status_model

// File: test/test_dual_source_clock_generator.sv
// Self-checking bench for the dual-source clock generator
`timescale 1ns/1ps

module test_dual_source_clock_generator
    import clkgen_pkg::*;
;
    // ----------
    // Signals
    // ----------
    logic       clk                      = 1'b0;
    logic       nrst                     = 1'b0;
    logic       crystal_input            = 1'b0;
    logic       external_frequency_input = 1'b0;
    logic       source_select            = SEL_CRYSTAL;
    logic       run                      = 1'b0;
    logic       bus_status_zero;
    logic       bus_status_one;
    logic       sys_clk_out;
    logic       periph_clk_out;
    logic       periph_phase_locked;
    int         n_mismatch, total_checks, wt, nr, nc, fc;
    int         xh = 2, eh = 3, xc, ec, hl = 2;
    bit         go, cur, sw, fz, orp, rsp, sp, xp, ep, pk, pv;
    bit         rx, fe, e_old, e_new, e_cnt, ex;
    bit   [1:0] hist;

    dual_source_clock_generator DUT (
        .clk                      (clk),
        .nrst                     (nrst),
        .crystal_input            (crystal_input),
        .external_frequency_input (external_frequency_input),
        .source_select            (source_select),
        .bus_status_zero          (bus_status_zero),
        .bus_status_one           (bus_status_one),
        .sys_clk_out              (sys_clk_out),
        .periph_clk_out           (periph_clk_out),
        .periph_phase_locked      (periph_phase_locked)
    );

    bus_status_model far_end (
        .clk             (clk),
        .nrst            (nrst),
        .sys_clk         (sys_clk_out),
        .run             (run),
        .bus_status_zero (bus_status_zero),
        .bus_status_one  (bus_status_one)
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    // Source oscillators, moved off the sampling edge
    always @(negedge clk) begin
        xc = xc + 1;
        ec = ec + 1;
        if (xc >= xh) begin
            xc = 0;
            crystal_input = ~crystal_input;
        end
        if (ec >= eh) begin
            ec = 0;
            external_frequency_input = ~external_frequency_input;
        end
    end

    // Counted compare
    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    // ----------
    // Reference model
    // ----------
    always @(posedge clk) begin
        rx = crystal_input & ~xp;
        fe = ep & ~external_frequency_input;
        e_old = cur ? fe : rx;
        e_new = cur ? rx : fe;
        e_cnt = cur ? (xp & ~crystal_input)
                    : (external_frequency_input & ~ep);
        if (go) begin
            // Running output copies the crystal, or the inverted external input, one clock late
            if (!sw) chk(sys_clk_out === (cur ? ~ep : xp), "clk path");
            if (sys_clk_out !== sp) begin
                chk(hl >= 2, "short clock phase");
                hl = 1;
            end else hl++;
            // Switch tracking: freeze point, then restart edge
            if (fz && sys_clk_out) begin
                chk(rsp, "restart edge");
                chk(nc == 2, "restart edge count");
                chk(fc <= 5 * (cur ? xh : eh) + 1, "restart late");
                cur = ~cur;
                sw = 0;
                fz = 0;
            end else if (fz) begin
                fc++;
                nc += e_cnt;
            end else if (sw) begin
                if (sys_clk_out && !sp) nr++;
                if (orp && !sys_clk_out) begin
                    chk(nr >= 2 && nr <= 4, "freeze delay");
                    fz = 1;
                    nc = e_cnt;
                    fc = 0;
                end
            end
            // Peripheral clock judged at each system clock fall
            if (!sys_clk_out && sp) begin
                ex = (hist == 2'h3) || !pk;
                if (pv) chk(periph_clk_out === ex, "pclk");
                pk = periph_clk_out;
                pv = 1;
                hist = {hist[0], ~(bus_status_zero & bus_status_one)};
            end
        end
        orp = e_old;
        rsp = e_new;
        sp = sys_clk_out;
        xp = crystal_input;
        ep = external_frequency_input;
    end

    // ----------
    // Stimulus
    // ----------
    initial begin
        void'($urandom(1));
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        go = 1'b1;
        // Idle bus, then bus cycles from the processor model
        repeat (200) @(negedge clk);
        chk(periph_phase_locked === 1'b0, "locked early");
        run = 1'b1;
        repeat (200) @(negedge clk);
        chk(periph_phase_locked === 1'b1, "not locked");
        run = 1'b0;
        // Switches both ways at random source rates
        for (int i = 0; i < 6; i++) begin
            repeat (100) @(negedge clk);
            xh = 2 + $urandom % 2;
            eh = 2 + $urandom % 4;
            nr = 0;
            source_select = ~source_select;
            sw = 1'b1;
            wt = 0;
            while (sw && wt < 500) begin
                @(negedge clk);
                wt++;
            end
            if (sw) begin
                chk(1'b0, "switch hang");
                final_report();
            end
        end
        repeat (100) @(negedge clk);
        chk(periph_phase_locked === 1'b1, "lock lost");
        final_report();
    end
endmodule : test_dual_source_clock_generator
